// File: rtl/sll_link_tx.v
// transmit link layer: scrambling, 8b/10b link bring-up and 64b/66b block framing
//
// Behaviour
// - scramble octets before 8b/10b coding, blocks before sync header insertion.
// - scrambling selectable in 8b/10b modes, always on in 64b/66b modes.
// - the lane alignment sequence is never scrambled.
// - every octet becomes a DC balanced 10-bit character in 8b/10b modes.
// - frames per multiframe limited by ceil(17/F) and min(256, floor(1024/F)).
// - SYSREF resets the multiframe clock; period is F times K characters in 8b/10b modes, 32 blocks in 64b/66b modes.
// - while SYNC is low, send K28.5 commas continuously.
// - after SYNC rises, wait for the next multiframe edge, then start alignment.
// - alignment spans four multiframes, each from K28.0 to K28.3.
// - the second alignment multiframe carries the link configuration.
// - unscrambled, a repeated frame-final octet becomes K28.7, or K28.3 at multiframe end.
// - scrambled, frame-final 0xFC becomes K28.7, multiframe-final 0x7C becomes K28.3.
// - 64b/66b packs eight octets, scrambles, then prepends a 2-bit header.
// - header at bits 0 to 1, octet n at bits 2+8n to 9+8n.
// - headers are 01 for a one and 10 for a zero.
// - every 32-bit header stream ends with 00001.
// - SYNC is ignored in 64b/66b modes.
`timescale 1ns/1ps
`include "sll_regs.vh"
module sll_link_tx (
    input  wire        clk,
    input  wire        reset_n,
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_write,
    input  wire        reg_read,
    output reg  [31:0] reg_rdata,
    input  wire        char_clk,
    input  wire        sysref,
    input  wire        sync_n,
    input  wire [7:0]  data_in,
    output reg         octet_taken,
    output wire [9:0]  tx_char,
    output reg         tx_char_valid,
    output reg  [65:0] tx_block,
    output reg         tx_block_valid,
    output reg         local_multiframe_clock_edge
);
    // ------------------------------------------------------------------------
    // scramblers
    // ------------------------------------------------------------------------
    // 1 + x^14 + x^15, msb first; returns {state, octet}
    function [22:0] scr8;
        input [7:0]  d;
        input [14:0] s;
        integer      i;
        reg   [14:0] st;
        reg   [7:0]  o;
        begin
            st = s;
            o  = 8'h00;
            for (i = 7; i >= 0; i = i - 1) begin
                o[i] = d[i] ^ st[13] ^ st[14];
                st   = {st[13:0], o[i]};
            end
            scr8 = {st, o};
        end
    endfunction

    // 1 + x^39 + x^58, bit 0 first; returns {state, block}
    function [121:0] scr64;
        input [63:0] d;
        input [57:0] s;
        integer      i;
        reg   [57:0] st;
        reg   [63:0] o;
        begin
            st = s;
            o  = 64'h0;
            for (i = 0; i < 64; i = i + 1) begin
                o[i] = d[i] ^ st[38] ^ st[57];
                st   = {st[56:0], o[i]};
            end
            scr64 = {st, o};
        end
    endfunction

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    reg        scr_en_q;
    reg        mode64_q;
    reg [7:0]  f_m1_q;
    reg [7:0]  k_m1_q;
    reg [7:0]  dev_id_q;
    reg [7:0]  lane_id_q;
    reg        cfg_reject_q;
    reg [1:0]  state_q;
    reg        local_multiframe_clock_ok_q;
    reg        sync_s2;

    wire [8:0]  wr_f   = {1'b0, reg_wdata[15:8] & 8'h00} | ({1'b0, reg_wdata[7:0]} + 9'h001);
    wire [8:0]  wr_k   = {1'b0, reg_wdata[15:8]} + 9'h001;
    wire [17:0] wr_prd = wr_f * wr_k;
    wire        wr_ok  = (wr_prd >= `SLL_MF_MIN_OCTETS) && (wr_prd <= `SLL_MF_MAX_OCTETS);
    wire        wr_frm = reg_write && (reg_addr == `SLL_ADDR_FRAME);

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scr_en_q     <= 1'b0;
            mode64_q     <= 1'b0;
            f_m1_q       <= `SLL_RST_F_M1;
            k_m1_q       <= `SLL_RST_K_M1;
            dev_id_q     <= `SLL_RST_DEV_ID;
            lane_id_q    <= `SLL_RST_LANE_ID;
            cfg_reject_q <= 1'b0;
        end else begin
            if (reg_write && reg_addr == `SLL_ADDR_CTRL) begin
                scr_en_q <= reg_wdata[`SLL_CTRL_SCR_BIT];
                mode64_q <= reg_wdata[`SLL_CTRL_MODE64_BIT];
            end
            if (wr_frm && wr_ok) begin
                f_m1_q <= reg_wdata[7:0];
                k_m1_q <= reg_wdata[15:8];
            end
            if (reg_write && reg_addr == `SLL_ADDR_INITIAL_LANE_ALIGNMENT_SEQ_PARAM) begin
                dev_id_q  <= reg_wdata[7:0];
                lane_id_q <= reg_wdata[15:8];
            end
            // out-of-range sizes are refused; set wins over the write-one clear
            if (wr_frm && !wr_ok) begin
                cfg_reject_q <= 1'b1;
            end else if (reg_write && reg_addr == `SLL_ADDR_STATUS
                         && reg_wdata[`SLL_STAT_REJECT_BIT]) begin
                cfg_reject_q <= 1'b0;
            end
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 32'h0;
        end else if (reg_read) begin
            case (reg_addr)
                `SLL_ADDR_CTRL:       reg_rdata <= {30'h0, mode64_q, scr_en_q};
                `SLL_ADDR_FRAME:      reg_rdata <= {16'h0, k_m1_q, f_m1_q};
                `SLL_ADDR_STATUS:     reg_rdata <= {23'h0, cfg_reject_q, 2'b00, sync_s2,
                                                    local_multiframe_clock_ok_q, 2'b00, state_q};
                `SLL_ADDR_INITIAL_LANE_ALIGNMENT_SEQ_PARAM: reg_rdata <= {16'h0, lane_id_q, dev_id_q};
                default:              reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

    // ------------------------------------------------------------------------
    // pin synchronisers and edge detection
    // ------------------------------------------------------------------------
    reg chk_s1, chk_s2, chk_s3;
    reg srf_s1, srf_s2, srf_s3;
    reg sync_s1, sync_d;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {chk_s1, chk_s2, chk_s3} <= 3'h0;
            {srf_s1, srf_s2, srf_s3} <= 3'h0;
            {sync_s1, sync_s2, sync_d} <= 3'h0;
        end else begin
            {chk_s1, chk_s2, chk_s3} <= {char_clk, chk_s1, chk_s2};
            {srf_s1, srf_s2, srf_s3} <= {sysref, srf_s1, srf_s2};
            {sync_s1, sync_s2, sync_d} <= {sync_n, sync_s1, sync_s2};
        end
    end

    wire tick      = chk_s2 & ~chk_s3;
    wire sref_edge = srf_s2 & ~srf_s3;
    wire sync_rise = sync_s2 & ~sync_d;

    // ------------------------------------------------------------------------
    // local multiframe clock and multiblock position
    // ------------------------------------------------------------------------
    reg [7:0] oct_q;
    reg [7:0] frm_q;
    reg [9:0] pos_q;
    reg [2:0] byte8_q;
    reg [4:0] mb_idx_q;

    wire frame_end = (oct_q == f_m1_q);
    wire mf_end    = frame_end && (frm_q == k_m1_q);
    wire mf_start  = (pos_q == 10'h000);

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            oct_q     <= 8'h00;
            frm_q     <= 8'h00;
            pos_q     <= 10'h000;
            byte8_q   <= 3'h0;
            mb_idx_q  <= 5'h00;
            local_multiframe_clock_ok_q <= 1'b0;
            local_multiframe_clock_edge <= 1'b0;
        end else begin
            local_multiframe_clock_edge <= tick && !sref_edge
                         && (mode64_q ? (byte8_q == 3'h0 && mb_idx_q == 5'h00) : mf_start);
            if (sref_edge) begin
                oct_q     <= 8'h00;
                frm_q     <= 8'h00;
                pos_q     <= 10'h000;
                byte8_q   <= 3'h0;
                mb_idx_q  <= 5'h00;
                local_multiframe_clock_ok_q <= 1'b1;
            end else if (tick) begin
                if (mf_end) begin
                    oct_q <= 8'h00;
                    frm_q <= 8'h00;
                    pos_q <= 10'h000;
                end else if (frame_end) begin
                    oct_q <= 8'h00;
                    frm_q <= frm_q + 8'h01;
                    pos_q <= pos_q + 10'h001;
                end else begin
                    oct_q <= oct_q + 8'h01;
                    pos_q <= pos_q + 10'h001;
                end
                byte8_q <= byte8_q + 3'h1;
                if (byte8_q == `SLL_BLK_LAST_OCTET) begin
                    mb_idx_q <= mb_idx_q + 5'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // 8b/10b link sequencing and character selection
    // ------------------------------------------------------------------------
    reg [1:0]  state_d;
    reg [1:0]  initial_lane_alignment_seq_mf_q;
    reg [1:0]  initial_lane_alignment_seq_mf_d;
    reg [14:0] scr8_st_q;
    reg [14:0] scr8_st_d;
    reg [7:0]  last_q;
    reg [7:0]  last_d;
    reg [7:0]  enc_d;
    reg        enc_k;
    reg [22:0] s8;
    reg        take;

    always @* begin
        state_d   = state_q;
        initial_lane_alignment_seq_mf_d = initial_lane_alignment_seq_mf_q;
        scr8_st_d = scr8_st_q;
        last_d    = last_q;
        enc_d     = `SLL_K28_5;
        enc_k     = 1'b1;
        take      = 1'b0;
        s8        = scr8(data_in, scr8_st_q);
        if (mode64_q) begin
            state_d = `SLL_ST_CGS;
        end else if (!sync_s2 || !local_multiframe_clock_ok_q) begin
            state_d = `SLL_ST_CGS;
        end else begin
            case (state_q)
                `SLL_ST_CGS: begin
                    if (sync_rise) begin
                        state_d = `SLL_ST_WAIT;
                    end
                end
                `SLL_ST_WAIT, `SLL_ST_INITIAL_LANE_ALIGNMENT_SEQ: begin
                    if (state_q == `SLL_ST_INITIAL_LANE_ALIGNMENT_SEQ || mf_start) begin
                        enc_k = 1'b0;
                        enc_d = pos_q[7:0];
                        if (mf_start) begin
                            enc_k = 1'b1;
                            enc_d = `SLL_K28_0;
                        end else if (mf_end) begin
                            enc_k = 1'b1;
                            enc_d = `SLL_K28_3;
                        end else if (initial_lane_alignment_seq_mf_q == 2'h1) begin
                            case (pos_q)
                                10'h001: begin
                                    enc_k = 1'b1;
                                    enc_d = `SLL_K28_4;
                                end
                                10'h002: enc_d = dev_id_q;
                                10'h003: enc_d = lane_id_q;
                                10'h004: enc_d = f_m1_q;
                                10'h005: enc_d = k_m1_q;
                                10'h006: enc_d = {6'h00, mode64_q, scr_en_q};
                                default: enc_d = pos_q[7:0];
                            endcase
                        end
                        state_d = `SLL_ST_INITIAL_LANE_ALIGNMENT_SEQ;
                        if (mf_end) begin
                            initial_lane_alignment_seq_mf_d = initial_lane_alignment_seq_mf_q + 2'h1;
                            if (initial_lane_alignment_seq_mf_q == `SLL_INITIAL_LANE_ALIGNMENT_SEQ_LAST_MF) begin
                                state_d = `SLL_ST_DATA;
                            end
                        end
                    end
                end
                `SLL_ST_DATA: begin
                    take  = 1'b1;
                    enc_k = 1'b0;
                    if (scr_en_q) begin
                        enc_d     = s8[7:0];
                        scr8_st_d = s8[22:8];
                        if (mf_end && s8[7:0] == `SLL_K28_3) begin
                            enc_k = 1'b1;
                        end else if (frame_end && s8[7:0] == `SLL_K28_7) begin
                            enc_k = 1'b1;
                        end
                    end else begin
                        enc_d = data_in;
                        if (frame_end) begin
                            last_d = data_in;
                            if (data_in == last_q) begin
                                enc_k = 1'b1;
                                enc_d = mf_end ? `SLL_K28_3 : `SLL_K28_7;
                            end
                        end
                    end
                end
                default: state_d = `SLL_ST_CGS;
            endcase
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q       <= `SLL_ST_CGS;
            initial_lane_alignment_seq_mf_q     <= 2'h0;
            scr8_st_q     <= 15'h0000;
            last_q        <= 8'h00;
            tx_char_valid <= 1'b0;
        end else begin
            tx_char_valid <= tick && !mode64_q;
            if (state_d == `SLL_ST_CGS || state_d == `SLL_ST_WAIT) begin
                state_q   <= state_d;
                initial_lane_alignment_seq_mf_q <= 2'h0;
            end else if (tick) begin
                state_q   <= state_d;
                initial_lane_alignment_seq_mf_q <= initial_lane_alignment_seq_mf_d;
                scr8_st_q <= scr8_st_d;
                last_q    <= last_d;
            end
        end
    end

    sll_enc8b10b u_enc (
        .clk     (clk),
        .reset_n (reset_n),
        .enable  (tick && !mode64_q),
        .is_k    (enc_k),
        .data_in (enc_d),
        .code_q  (tx_char)
    );

    // ------------------------------------------------------------------------
    // 64b/66b block assembly
    // ------------------------------------------------------------------------
    reg  [55:0]  acc_q;
    reg  [57:0]  scr64_st_q;
    wire [121:0] s64  = scr64({data_in, acc_q}, scr64_st_q);
    wire         shb  = (mb_idx_q == `SLL_MB_LAST_BLOCK) ? 1'b1
                      : (mb_idx_q >= `SLL_END_OF_MULTIBLOCK_MARKER_FIRST) ? 1'b0 : 1'b1;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_q          <= 56'h0;
            scr64_st_q     <= 58'h0;
            tx_block       <= 66'h0;
            tx_block_valid <= 1'b0;
            octet_taken    <= 1'b0;
        end else begin
            octet_taken    <= tick && (mode64_q || take);
            tx_block_valid <= tick && mode64_q && !sref_edge
                              && (byte8_q == `SLL_BLK_LAST_OCTET);
            if (tick && mode64_q && !sref_edge) begin
                if (byte8_q == `SLL_BLK_LAST_OCTET) begin
                    tx_block   <= {s64[63:0], shb, ~shb};
                    scr64_st_q <= s64[121:64];
                end else begin
                    acc_q[byte8_q * 8 +: 8] <= data_in;
                end
            end
        end
    end
endmodule // sll_link_tx

// File: rtl/sll_regs.vh
// register map, field positions, reset values and link constants of the link layer transmitter
`ifndef SLL_REGS_VH
`define SLL_REGS_VH

// ----------------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------------
`define SLL_ADDR_CTRL        8'h00
`define SLL_ADDR_FRAME       8'h04
`define SLL_ADDR_STATUS      8'h08
`define SLL_ADDR_INITIAL_LANE_ALIGNMENT_SEQ_PARAM  8'h0C

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define SLL_CTRL_SCR_BIT     0
`define SLL_CTRL_MODE64_BIT  1
`define SLL_FRAME_F_LSB      0
`define SLL_FRAME_K_LSB      8
`define SLL_STAT_LOCAL_MULTIFRAME_CLOCK_BIT    4
`define SLL_STAT_SYNC_BIT    5
`define SLL_STAT_REJECT_BIT  8

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define SLL_RST_F_M1         8'h01
`define SLL_RST_K_M1         8'h1F
`define SLL_RST_DEV_ID       8'h00
`define SLL_RST_LANE_ID      8'h00

// ----------------------------------------------------------------------------
// multiframe size limits, expressed on the product octets x frames
// ----------------------------------------------------------------------------
`define SLL_MF_MIN_OCTETS    18'h00011
`define SLL_MF_MAX_OCTETS    18'h00400

// ----------------------------------------------------------------------------
// control characters (octet value, sent with the k flag)
// ----------------------------------------------------------------------------
`define SLL_K28_0            8'h1C
`define SLL_K28_3            8'h7C
`define SLL_K28_4            8'h9C
`define SLL_K28_5            8'hBC
`define SLL_K28_7            8'hFC

// ----------------------------------------------------------------------------
// link sequencing
// ----------------------------------------------------------------------------
`define SLL_INITIAL_LANE_ALIGNMENT_SEQ_LAST_MF     2'h3
`define SLL_MB_LAST_BLOCK    5'h1F
`define SLL_END_OF_MULTIBLOCK_MARKER_FIRST       5'h1B
`define SLL_BLK_LAST_OCTET   3'h7

`define SLL_ST_CGS           2'h0
`define SLL_ST_WAIT          2'h1
`define SLL_ST_INITIAL_LANE_ALIGNMENT_SEQ          2'h2
`define SLL_ST_DATA          2'h3

`endif

// File: rtl/sll_enc8b10b.v
// 8b/10b character encoder with running disparity
`timescale 1ns/1ps
module sll_enc8b10b (
    input  wire       clk,
    input  wire       reset_n,
    input  wire       enable,
    input  wire       is_k,
    input  wire [7:0] data_in,
    output reg  [9:0] code_q
);
    reg       rd_q;
    reg       rd_d;
    reg       rd_mid;
    reg [5:0] b6;
    reg [3:0] b4;
    reg [5:0] c6;
    reg [3:0] c4;
    reg       alt;
    reg [2:0] ones6;
    reg [2:0] ones4;
    wire [4:0] x = data_in[4:0];
    wire [2:0] y = data_in[7:5];

    // ------------------------------------------------------------------------
    // code selection, tables written for negative running disparity
    // ------------------------------------------------------------------------
    always @* begin
        case (x)
            5'h00: b6 = 6'b100111;  5'h01: b6 = 6'b011101;
            5'h02: b6 = 6'b101101;  5'h03: b6 = 6'b110001;
            5'h04: b6 = 6'b110101;  5'h05: b6 = 6'b101001;
            5'h06: b6 = 6'b011001;  5'h07: b6 = 6'b111000;
            5'h08: b6 = 6'b111001;  5'h09: b6 = 6'b100101;
            5'h0A: b6 = 6'b010101;  5'h0B: b6 = 6'b110100;
            5'h0C: b6 = 6'b001101;  5'h0D: b6 = 6'b101100;
            5'h0E: b6 = 6'b011100;  5'h0F: b6 = 6'b010111;
            5'h10: b6 = 6'b011011;  5'h11: b6 = 6'b100011;
            5'h12: b6 = 6'b010011;  5'h13: b6 = 6'b110010;
            5'h14: b6 = 6'b001011;  5'h15: b6 = 6'b101010;
            5'h16: b6 = 6'b011010;  5'h17: b6 = 6'b111010;
            5'h18: b6 = 6'b110011;  5'h19: b6 = 6'b100110;
            5'h1A: b6 = 6'b010110;  5'h1B: b6 = 6'b110110;
            5'h1C: b6 = 6'b001110;  5'h1D: b6 = 6'b101110;
            5'h1E: b6 = 6'b011110;  default: b6 = 6'b101011;
        endcase
        // only K28.x control characters are used by this link
        if (is_k) begin
            b6 = 6'b001111;
        end
        ones6 = {2'b00, b6[0]} + {2'b00, b6[1]} + {2'b00, b6[2]}
              + {2'b00, b6[3]} + {2'b00, b6[4]} + {2'b00, b6[5]};
        c6 = (rd_q && (ones6 != 3'h3 || x == 5'h07)) ? ~b6 : b6;
        rd_mid = (ones6 != 3'h3) ? ~rd_q : rd_q;
        alt = is_k || (!rd_mid && (x == 5'h11 || x == 5'h12 || x == 5'h14))
                   || (rd_mid && (x == 5'h0B || x == 5'h0D || x == 5'h0E));
        case (y)
            3'h0: b4 = 4'b1011;
            3'h1: b4 = 4'b1001;
            3'h2: b4 = 4'b0101;
            3'h3: b4 = 4'b1100;
            3'h4: b4 = 4'b1101;
            3'h5: b4 = 4'b1010;
            3'h6: b4 = 4'b0110;
            default: b4 = alt ? 4'b0111 : 4'b1110;
        endcase
        ones4 = {2'b00, b4[0]} + {2'b00, b4[1]} + {2'b00, b4[2]} + {2'b00, b4[3]};
        // control characters invert their balanced tails under negative mid disparity
        if ((rd_mid && (ones4 != 3'h2 || y == 3'h3))
            || (is_k && !rd_mid && ones4 == 3'h2 && y != 3'h3)) begin
            c4 = ~b4;
        end else begin
            c4 = b4;
        end
        rd_d = (ones4 != 3'h2) ? ~rd_mid : rd_mid;
    end

    // ------------------------------------------------------------------------
    // output register and disparity state
    // ------------------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            code_q <= 10'h000;
            rd_q   <= 1'b0;
        end else if (enable) begin
            code_q <= {c6, c4};
            rd_q   <= rd_d;
        end
    end
endmodule // sll_enc8b10b

// File: tb/sll_link_tx_checker.sv
// port assertions of the link transmitter
`timescale 1ns/1ps
module sll_chk (
    input wire        clk,
    input wire        reset_n,
    input wire        sync_n,
    input wire        octet_taken,
    input wire [9:0]  tx_char,
    input wire        tx_char_valid,
    input wire [65:0] tx_block,
    input wire        tx_block_valid,
    input wire        local_multiframe_clock_edge
);
    reg        rd_q;
    wire [3:0] n1 = 4'($countones(tx_char));
    wire       k5 = tx_char == 10'h0FA || tx_char == 10'h305;
    wire       k0 = tx_char == 10'h0F4 || tx_char == 10'h30B;
    // running disparity, negative after reset
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            rd_q <= 1'b0;
        else
            rd_q <= rd_q ^ (tx_char_valid && n1 != 4'h5);
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    AST_DC: assert property (tx_char_valid |-> n1 >= 4'h4 && n1 <= 4'h6)
        else $error("unbalanced character");
    AST_RD: assert property (tx_char_valid && n1 != 4'h5 |-> (n1 == 4'h6) == !rd_q)
        else $error("wrong disparity");
    AST_CGS: assert property (tx_char_valid && !sync_n && !$past(sync_n, 5) |-> k5)
        else $error("no comma while sync low");
    AST_K0: assert property (tx_char_valid && k0 |-> local_multiframe_clock_edge)
        else $error("start character off the edge");
    AST_SH: assert property (tx_block_valid |-> tx_block[0] != tx_block[1])
        else $error("header bits equal");
    AST_BLK: assert property (tx_block_valid |=> !tx_block_valid [*8])
        else $error("blocks too close");
    AST_LMF: assert property (local_multiframe_clock_edge |-> tx_char_valid || octet_taken)
        else $error("edge off a tick");
    AST_PUL: assert property (local_multiframe_clock_edge |=> !local_multiframe_clock_edge)
        else $error("edge too long");
    cover property (tx_char_valid && k0);
    cover property (tx_block_valid);
    cover property (local_multiframe_clock_edge && octet_taken);
endmodule // sll_chk
bind sll_link_tx sll_chk sll_chk_i (.clk, .reset_n, .sync_n, .octet_taken, .tx_char,
    .tx_char_valid, .tx_block, .tx_block_valid, .local_multiframe_clock_edge);

// File: tb/sll_rx_model.sv
// link receiver model driving the sync request
`timescale 1ns/1ps
module sll_rx_model (
    input  wire       clk,
    input  wire       req,
    input  wire [9:0] tx_char,
    input  wire       tx_char_valid,
    input  wire       local_multiframe_clock_edge,
    output reg        sync_n = 1'b0
);
    reg [2:0] cnt_q = 3'h0;
    always @(posedge clk) begin
        if (req) begin
            sync_n <= 1'b0;
            cnt_q <= 3'h0;
        end else if (tx_char_valid && cnt_q != 3'h4)
            cnt_q <= (tx_char == 10'h0FA || tx_char == 10'h305) ? cnt_q + 3'h1 : 3'h0;
        else if (cnt_q == 3'h4 && local_multiframe_clock_edge)
            sync_n <= 1'b1;
    end
endmodule // sll_rx_model

// File: tb/sll_link_tx_tb_top.sv
// self-checking bench of the link transmitter
`timescale 1ns/1ps
module sll_link_tx_tb_top;
    reg         clk = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    reg         char_clk = 1'b0, sysref = 1'b0, req = 1'b1, fix = 1'b0;
    reg  [7:0]  reg_addr = 8'h0, data_in = 8'h0, nk = 8'h0;
    reg  [31:0] reg_wdata = 32'h0, hs = 32'h0, seed = 32'h6941B860;
    integer     error_cnt = 0, cmp_count = 0, cyc = 0, i;
    wire [31:0] reg_rdata;
    wire [9:0]  tx_char;
    wire [65:0] tx_block;
    wire        sync_n, octet_taken, tx_char_valid, tx_block_valid, local_multiframe_clock_edge;
    sll_link_tx sll_link_tx_i (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .char_clk, .sysref, .sync_n, .data_in, .octet_taken, .tx_char,
        .tx_char_valid, .tx_block, .tx_block_valid, .local_multiframe_clock_edge);
    sll_rx_model sll_rx_model_i (.clk, .req, .tx_char, .tx_char_valid, .local_multiframe_clock_edge, .sync_n);
    initial forever #50 clk = ~clk;
    initial begin
        #137;
        forever #400 char_clk = ~char_clk;
    end
    task chk(input [31:0] got, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] v);
        begin
            @(posedge clk);
            reg_addr <= a;
            reg_wdata <= v;
            reg_write <= 1'b1;
            @(posedge clk);
            reg_write <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [31:0] e);
        begin
            @(posedge clk);
            reg_addr <= a;
            reg_read <= 1'b1;
            @(posedge clk);
            reg_read <= 1'b0;
            #1 chk(reg_rdata, e);
        end
    endtask
    task final_report;
        begin
            $display("compares %0d mismatches %0d", cmp_count, error_cnt);
            if (error_cnt == 0 && cmp_count > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (tx_char_valid && (tx_char == 10'h0F8 || tx_char == 10'h307 || tx_char == 10'h0F3
            || tx_char == 10'h30C))
            nk <= nk + 8'h1;
        if (tx_block_valid)
            hs <= {hs[30:0], tx_block[1]};
        if (octet_taken)
            data_in <= fix ? 8'h5A : 8'($random(seed));
        if (cyc == 30000) begin
            error_cnt = error_cnt + 1;
            final_report;
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        rd(8'h08, 32'h0);
        wr(8'h04, 32'h0F00);
        rd(8'h04, 32'h1F01);
        rd(8'h08, 32'h100);
        wr(8'h08, 32'h100);
        rd(8'h10, 32'h0);
        $display("registers done");
        for (i = 0; i < 2; i = i + 1) begin
            // realignment reissues the timing reference before the sync request
            sysref <= 1'b1;
            repeat (4) @(posedge clk);
            sysref <= 1'b0;
            req <= 1'b1;
            repeat (20) @(posedge clk);
            req <= 1'b0;
            @(posedge clk iff sync_n);
            @(posedge clk iff local_multiframe_clock_edge);
            chk(tx_char == 10'h0F4 || tx_char == 10'h30B, 32'h1);
            repeat (5) @(posedge clk iff local_multiframe_clock_edge);
            rd(8'h08, 32'h33);
            $display("link up");
        end
        fix <= 1'b1;
        repeat (2) @(posedge clk iff local_multiframe_clock_edge);
        nk <= 8'h0;
        @(posedge clk iff local_multiframe_clock_edge);
        chk(nk, 32'h20);
        $display("alignment done");
        wr(8'h00, 32'h1);
        repeat (2) @(posedge clk iff local_multiframe_clock_edge);
        nk <= 8'h0;
        @(posedge clk iff local_multiframe_clock_edge);
        chk(nk != 8'h20, 32'h1);
        $display("scrambled done");
        wr(8'h00, 32'h2);
        repeat (40) @(posedge clk iff tx_block_valid);
        @(posedge clk iff local_multiframe_clock_edge);
        chk(hs[4:0], 32'h1);
        chk(tx_block[65:2] !== {8{8'h5A}}, 32'h1);
        $display("blocks done");
        final_report;
    end
endmodule // sll_link_tx_tb_top
